// *** rtl/lrt_timer.sv ***
// loop-resolution timer: eight pwm, eight edge counters, eight measurement channels
`timescale 1ns/1ps
module lrt_timer import lrt_pkg::*; #(
  parameter int FINE_PRESCALE = 1,
  parameter int LOOP_PRESCALE = 128
) (
  input wire logic clk,
  input wire logic reset,
  input wire lrt_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pins_in,
  output logic [31:0] pins_out,
  output logic event_pending
);

  if (FINE_PRESCALE < 1 || FINE_PRESCALE > 256) begin : g_chk_fine
    $error("fine prescale out of range");
  end
  if (LOOP_PRESCALE < 1 || LOOP_PRESCALE > 256) begin : g_chk_loop
    $error("loop prescale out of range");
  end

  localparam logic [7:0] FINE_RST = 8'(FINE_PRESCALE - 1);
  localparam logic [7:0] LOOP_RST = 8'(LOOP_PRESCALE - 1);

  typedef struct packed {
    lrt_bus_e bus;
    logic [31:0] rdata;
    logic err;
    logic run;
    logic [7:0] fine_pre;
    logic [7:0] loop_pre;
    logic [7:0] fine_cnt;
    logic [7:0] loop_cnt;
    logic tick;
    logic [24:0] loop_time;
    logic [31:0] pins_prev;
    logic [31:0] pins_out;
    logic [23:0] int_en;
    logic [23:0] flags;
    logic pend;
    lrt_pwm_s [LRT_CH-1:0] pwm;
    lrt_edge_s [LRT_CH-1:0] edg;
    lrt_cap_s [LRT_CH-1:0] cap;
  } lrt_state_s;

  lrt_state_s s_q;
  lrt_state_s s_d;

  function automatic logic pin_at(input logic [31:0] v, input logic [4:0] sel);
    pin_at = v[sel];
  endfunction : pin_at

  function automatic logic [24:0] sat_inc(input logic [24:0] v);
    sat_inc = (v == LRT_CNT_MAX) ? v : v + LRT_CNT_ONE;
  endfunction : sat_inc

  function automatic logic [31:0] zx(input logic [24:0] v);
    zx = {7'h00, v};
  endfunction : zx

  logic [7:0] ev_per;
  logic [7:0] ev_duty;
  logic [7:0] ev_edge;
  logic [23:0] flag_clr;
  logic [31:0] out_acc;
  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic [2:0] ch;
  logic [1:0] wsel;
  logic [3:0] bank;
  logic [4:0] ap;
  logic [4:0] pp;
  logic a_now;
  logic a_was;
  logic p_now;
  logic p_was;
  logic e_now;
  logic e_was;
  logic [24:0] nxt_duty;

  always_comb begin
    s_d = s_q;
    ev_per = 8'h00;
    ev_duty = 8'h00;
    ev_edge = 8'h00;
    flag_clr = 24'h000000;
    out_acc = 32'h00000000;
    acc = 1'b0;
    wr = 1'b0;
    hit = 1'b0;
    rd = 32'h00000000;
    ch = apb_req.paddr[6:4];
    wsel = apb_req.paddr[3:2];
    bank = apb_req.paddr[11:8];
    ap = 5'h00;
    pp = 5'h00;
    a_now = 1'b0;
    a_was = 1'b0;
    p_now = 1'b0;
    p_was = 1'b0;
    e_now = 1'b0;
    e_was = 1'b0;
    nxt_duty = 25'h0000000;

    // loop tick from fine prescale then loop prescale
    s_d.tick = 1'b0;
    if (s_q.run) begin
      if (s_q.fine_cnt >= s_q.fine_pre) begin
        s_d.fine_cnt = 8'h00;
        if (s_q.loop_cnt >= s_q.loop_pre) begin
          s_d.loop_cnt = 8'h00;
          s_d.tick = 1'b1;
        end else begin
          s_d.loop_cnt = s_q.loop_cnt + 8'h01;
        end
      end else begin
        s_d.fine_cnt = s_q.fine_cnt + 8'h01;
      end
    end

    // one service pass per loop: pwm, then edges, then measurement
    if (s_q.tick) begin
      s_d.loop_time = (s_q.loop_time == LRT_CNT_MAX) ? 25'h0000000 : s_q.loop_time + LRT_CNT_ONE;
      s_d.pins_prev = pins_in;
      for (int i = 0; i < LRT_CH; i++) begin
        if (s_q.pwm[i].per_cnt == 25'h0000000) begin
          // working counters reloaded from shadow only here
          s_d.pwm[i].per_cnt = (s_q.pwm[i].per == 25'h0000000) ? 25'h0000000
                               : s_q.pwm[i].per - LRT_CNT_ONE;
          nxt_duty = s_q.pwm[i].duty;
          ev_per[i] = 1'b1;
        end else begin
          s_d.pwm[i].per_cnt = s_q.pwm[i].per_cnt - LRT_CNT_ONE;
          nxt_duty = (s_q.pwm[i].duty_cnt == 25'h0000000) ? 25'h0000000
                     : s_q.pwm[i].duty_cnt - LRT_CNT_ONE;
        end
        if (s_q.pwm[i].duty_cnt != 25'h0000000 && nxt_duty == 25'h0000000) begin
          ev_duty[i] = 1'b1;
        end
        s_d.pwm[i].duty_cnt = nxt_duty;
      end
      for (int i = 0; i < LRT_CH; i++) begin
        e_now = pin_at(pins_in, s_q.edg[i].pin);
        e_was = pin_at(s_q.pins_prev, s_q.edg[i].pin);
        if ((s_q.edg[i].rise && e_now && !e_was) ||
            (!s_q.edg[i].rise && !e_now && e_was)) begin
          s_d.edg[i].cnt = s_q.edg[i].cnt + LRT_CNT_ONE;
          ev_edge[i] = 1'b1;
        end
      end
      for (int i = 0; i < LRT_CH; i++) begin
        ap = {s_q.cap[i].pair, 1'b0};
        pp = {s_q.cap[i].pair, 1'b1};
        a_now = pin_at(pins_in, ap) == s_q.cap[i].pol;
        a_was = pin_at(s_q.pins_prev, ap) == s_q.cap[i].pol;
        p_now = pin_at(pins_in, pp) == s_q.cap[i].pol;
        p_was = pin_at(s_q.pins_prev, pp) == s_q.cap[i].pol;
        if (a_now && !a_was) begin
          s_d.cap[i].act_run = 25'h0000000;
        end else if (a_now) begin
          s_d.cap[i].act_run = sat_inc(s_q.cap[i].act_run);
        end else if (a_was) begin
          s_d.cap[i].act_meas = s_q.cap[i].act_run;
        end
        if (p_now && !p_was) begin
          s_d.cap[i].per_meas = s_q.cap[i].per_run;
          s_d.cap[i].per_run = 25'h0000000;
          s_d.cap[i].stamp = s_q.loop_time;
        end else begin
          s_d.cap[i].per_run = sat_inc(s_q.cap[i].per_run);
        end
      end
    end

    // pin drive from duty state, polarity and enable
    for (int i = 0; i < LRT_CH; i++) begin
      if (s_d.pwm[i].en) begin
        out_acc[s_d.pwm[i].pin] = out_acc[s_d.pwm[i].pin] |
          ((s_d.pwm[i].duty_cnt != 25'h0000000) ~^ s_d.pwm[i].pol);
      end
    end
    s_d.pins_out = out_acc;

    // apb slave: answer in the cycle after setup
    acc = apb_req.psel && apb_req.penable && (s_q.bus == LRT_BUS_ACK);
    wr = acc && apb_req.pwrite;
    s_d.bus = LRT_BUS_IDLE;
    s_d.err = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      s_d.bus = LRT_BUS_ACK;
      if (apb_req.paddr == LRT_CTRL) begin
        hit = 1'b1;
        rd = {31'h00000000, s_q.run};
      end else if (apb_req.paddr == LRT_PRESCALE) begin
        hit = 1'b1;
        rd = {16'h0000, s_q.loop_pre, s_q.fine_pre};
      end else if (apb_req.paddr == LRT_INT_EN_SET || apb_req.paddr == LRT_INT_EN_CLR) begin
        hit = 1'b1;
        rd = {8'h00, s_q.int_en};
      end else if (apb_req.paddr == LRT_FLAGS) begin
        hit = 1'b1;
        rd = {8'h00, s_q.flags};
      end else if (apb_req.paddr == LRT_LOOP_TIME) begin
        hit = 1'b1;
        rd = zx(s_q.loop_time);
      end else if (apb_req.paddr[7] || apb_req.paddr[1:0] != 2'h0) begin
        hit = 1'b0;
      end else if (bank == LRT_BANK_PWM) begin
        hit = wsel != LRT_W3;
        if (wsel == LRT_W0) begin
          rd = zx(s_q.pwm[ch].per);
        end else if (wsel == LRT_W1) begin
          rd = zx(s_q.pwm[ch].duty);
        end else begin
          rd = {22'h000000, s_q.pwm[ch].en, s_q.pwm[ch].pol, 3'h0, s_q.pwm[ch].pin};
        end
      end else if (bank == LRT_BANK_EDGE) begin
        hit = wsel == LRT_W0 || wsel == LRT_W1;
        if (wsel == LRT_W0) begin
          rd = {23'h000000, s_q.edg[ch].rise, 3'h0, s_q.edg[ch].pin};
        end else begin
          rd = zx(s_q.edg[ch].cnt);
        end
      end else if (bank == LRT_BANK_CAP) begin
        hit = 1'b1;
        if (wsel == LRT_W0) begin
          rd = {23'h000000, s_q.cap[ch].pol, 4'h0, s_q.cap[ch].pair};
        end else if (wsel == LRT_W1) begin
          rd = zx(s_q.cap[ch].act_meas);
        end else if (wsel == LRT_W2) begin
          rd = zx(s_q.cap[ch].per_meas);
        end else begin
          rd = zx(s_q.cap[ch].stamp);
        end
      end
      s_d.rdata = hit ? rd : 32'h00000000;
      s_d.err = !hit;
    end

    if (wr && !s_q.err) begin
      if (apb_req.paddr == LRT_CTRL) begin
        s_d.run = apb_req.pwdata[0];
      end else if (apb_req.paddr == LRT_PRESCALE) begin
        s_d.fine_pre = apb_req.pwdata[LRT_FINE_LSB +: 8];
        s_d.loop_pre = apb_req.pwdata[LRT_LOOP_LSB +: 8];
      end else if (apb_req.paddr == LRT_INT_EN_SET) begin
        s_d.int_en = s_q.int_en | apb_req.pwdata[23:0];
      end else if (apb_req.paddr == LRT_INT_EN_CLR) begin
        s_d.int_en = s_q.int_en & ~apb_req.pwdata[23:0];
      end else if (apb_req.paddr == LRT_FLAGS) begin
        flag_clr = apb_req.pwdata[23:0];
      end else if (bank == LRT_BANK_PWM) begin
        if (wsel == LRT_W0) begin
          s_d.pwm[ch].per = apb_req.pwdata[24:0];
        end else if (wsel == LRT_W1) begin
          s_d.pwm[ch].duty = apb_req.pwdata[24:0];
        end else if (wsel == LRT_W2) begin
          s_d.pwm[ch].pin = apb_req.pwdata[4:0];
          s_d.pwm[ch].pol = apb_req.pwdata[LRT_POL_BIT];
          s_d.pwm[ch].en = apb_req.pwdata[LRT_EN_BIT];
        end
      end else if (bank == LRT_BANK_EDGE) begin
        if (wsel == LRT_W0) begin
          s_d.edg[ch].pin = apb_req.pwdata[4:0];
          s_d.edg[ch].rise = apb_req.pwdata[LRT_POL_BIT];
        end else if (wsel == LRT_W1) begin
          s_d.edg[ch].cnt = apb_req.pwdata[24:0];
        end
      end else if (bank == LRT_BANK_CAP) begin
        if (wsel == LRT_W0) begin
          s_d.cap[ch].pair = apb_req.pwdata[3:0];
          s_d.cap[ch].pol = apb_req.pwdata[LRT_POL_BIT];
        end
      end
    end

    // sticky event flags, a new event beats a clear
    s_d.flags = (s_q.flags & ~flag_clr) | {ev_edge, ev_duty, ev_per};
    s_d.pend = |(s_d.flags & s_d.int_en);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.bus <= LRT_BUS_IDLE;
      s_q.fine_pre <= FINE_RST;
      s_q.loop_pre <= LOOP_RST;
      for (int i = 0; i < LRT_CH; i++) begin
        s_q.pwm[i].pol <= 1'b1;
        s_q.cap[i].pol <= 1'b1;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = (s_q.bus == LRT_BUS_ACK);
  assign pslverr = s_q.err && (s_q.bus == LRT_BUS_ACK);
  assign pins_out = s_q.pins_out;
  assign event_pending = s_q.pend;

endmodule : lrt_timer

// *** rtl/lrt_pkg.sv ***
// constants, field layouts and state types of the loop-resolution timer
package lrt_pkg;
  localparam int LRT_CH = 8;
  localparam int LRT_CW = 25;
  localparam int LRT_PINS = 32;
  localparam logic [24:0] LRT_CNT_MAX = 25'h1FFFFFF;
  localparam logic [24:0] LRT_CNT_ONE = 25'h0000001;
  // global registers
  localparam logic [11:0] LRT_CTRL = 12'h000;
  localparam logic [11:0] LRT_PRESCALE = 12'h004;
  localparam logic [11:0] LRT_INT_EN_SET = 12'h008;
  localparam logic [11:0] LRT_INT_EN_CLR = 12'h00C;
  localparam logic [11:0] LRT_FLAGS = 12'h010;
  localparam logic [11:0] LRT_LOOP_TIME = 12'h014;
  // channel banks, 16 bytes per channel
  localparam logic [3:0] LRT_BANK_PWM = 4'h1;
  localparam logic [3:0] LRT_BANK_EDGE = 4'h2;
  localparam logic [3:0] LRT_BANK_CAP = 4'h3;
  localparam logic [1:0] LRT_W0 = 2'h0;
  localparam logic [1:0] LRT_W1 = 2'h1;
  localparam logic [1:0] LRT_W2 = 2'h2;
  localparam logic [1:0] LRT_W3 = 2'h3;
  // field positions
  localparam int LRT_POL_BIT = 8;
  localparam int LRT_EN_BIT = 9;
  localparam int LRT_FINE_LSB = 0;
  localparam int LRT_LOOP_LSB = 8;
  localparam int LRT_DUTY_FLAG_LSB = 8;
  localparam int LRT_EDGE_FLAG_LSB = 16;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lrt_apb_req_s;

  typedef struct packed {
    logic [24:0] per;
    logic [24:0] duty;
    logic [24:0] per_cnt;
    logic [24:0] duty_cnt;
    logic [4:0] pin;
    logic pol;
    logic en;
  } lrt_pwm_s;

  typedef struct packed {
    logic [4:0] pin;
    logic rise;
    logic [24:0] cnt;
  } lrt_edge_s;

  typedef struct packed {
    logic [3:0] pair;
    logic pol;
    logic [24:0] act_run;
    logic [24:0] per_run;
    logic [24:0] act_meas;
    logic [24:0] per_meas;
    logic [24:0] stamp;
  } lrt_cap_s;

  typedef enum logic [1:0] {
    LRT_BUS_IDLE = 2'b01,
    LRT_BUS_ACK = 2'b10
  } lrt_bus_e;
endpackage : lrt_pkg

// *** sim/lrt_timer_checker.sv ***
// assertions on the timer's bus and pin ports
`timescale 1ns/1ps
module lrt_timer_checker import lrt_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire lrt_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] pins_out,
  input wire logic event_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic setup = apb_req.psel && !apb_req.penable;
  ready_after_setup_a: assert property (setup |=> pready) else $error("ready missing");
  ready_in_access_a: assert property (pready |-> apb_req.psel && apb_req.penable)
    else $error("ready outside access");
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready held");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  misalign_err_a: assert property (setup && apb_req.paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned not refused");
  ctrl_no_err_a: assert property (setup && apb_req.paddr == LRT_CTRL |=> !pslverr)
    else $error("control refused");
  err_data_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("error with data");
  quiet_after_reset_a: assert property ($fell(reset) |-> pins_out == 32'h0 && !event_pending)
    else $error("outputs active after reset");
  cover property (setup && apb_req.pwrite ##1 pready);
  cover property (setup && !apb_req.pwrite ##1 pready);
  cover property (pslverr);
endmodule : lrt_timer_checker

bind lrt_timer lrt_timer_checker i_lrt_timer_checker (.clk(clk), .reset(reset),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins_out(pins_out), .event_pending(event_pending));

// *** sim/lrt_pins_model.sv ***
// external pin source: one square wave on every timer input
`timescale 1ns/1ps
module lrt_pins_model (
  input wire logic clk,
  input wire logic [7:0] per,
  input wire logic [7:0] hi,
  output logic [31:0] pins_in
);
  logic [7:0] ph_q = 8'h00;
  // phase restarts while stopped; edges stay more than one loop apart
  always @(posedge clk) begin
    if (hi == 8'h00 || ph_q + 8'h01 >= per) begin
      ph_q <= 8'h00;
    end else begin
      ph_q <= ph_q + 8'h01;
    end
  end
  assign pins_in = {32{ph_q < hi}};
endmodule : lrt_pins_model

// *** sim/lrt_timer_bench.sv ***
// self-checking bench for the loop-resolution timer
`timescale 1ns/1ps
module lrt_timer_bench import lrt_pkg::*; ;
  logic clk;
  logic reset;
  lrt_apb_req_s req;
  logic [31:0] prdata;
  logic [31:0] pins_in;
  logic [31:0] pins_out;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic event_pending;
  logic err;
  logic [7:0] per;
  logic [7:0] hi;
  int mismatches;
  int compares;

  lrt_timer i_lrt_timer (.clk(clk), .reset(reset), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out),
    .event_pending(event_pending));
  lrt_pins_model i_lrt_pins_model (.clk(clk), .per(per), .hi(hi), .pins_in(pins_in));

  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0, rd, err);
    chk(nm, rd, x);
  endtask : rd_chk

  task automatic check_pwm();
    int tp[7] = '{4, 4, 3, 1, 1, 2, 4};
    int td[7] = '{1, 1, 2, 1, 0, 1, 1};
    int tc[7] = '{'h308, 'h208, 'h308, 'h308, 'h308, 'h308, 'h108};
    int te[7] = '{6, 18, 16, 24, 0, 12, 0};
    int h;
    for (int i = 0; i < 7; i++) begin
      wr(12'h100, tp[i]);
      wr(12'h104, td[i]);
      wr(12'h108, tc[i]);
      repeat (12) @(posedge clk);
      h = 0;
      repeat (24) begin
        @(posedge clk);
        h += (pins_out[8] === 1'b1);
      end
      chk("pwm active loops", h, te[i]);
    end
  endtask : check_pwm

  task automatic check_edges();
    for (int r = 0; r < 2; r++) begin
      wr(12'h200, 32'h9 | (r << 8));
      wr(12'h204, 32'h0);
      hi <= 8'd3;
      repeat (80) @(posedge clk);
      hi <= 8'd0;
      repeat (8) @(posedge clk);
      rd_chk(12'h204, 32'd10, "edge count");
    end
  endtask : check_edges

  task automatic check_capture();
    logic [31:0] st;
    wr(12'h300, 32'h100);
    hi <= 8'd3;
    repeat (40) @(posedge clk);
    rd_chk(12'h304, 32'd2, "active time");
    rd_chk(12'h308, 32'd7, "period");
    apb(1'b0, 12'h30C, 32'h0, st, err);
    apb(1'b0, LRT_LOOP_TIME, 32'h0, rd, err);
    chk("stamp age", ((rd - st) & 32'h1FFFFFF) <= 32'd16, 32'h1);
    hi <= 8'd0;
  endtask : check_capture

  task automatic check_regs();
    wr(LRT_INT_EN_SET, 32'h1);
    rd_chk(LRT_INT_EN_CLR, 32'h1, "enables");
    chk("pending", event_pending, 32'h1);
    wr(LRT_INT_EN_CLR, 32'h1);
    rd_chk(LRT_INT_EN_SET, 32'h0, "enables");
    chk("pending", event_pending, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0, rd, err);
    chk("unmapped error", err, 32'h1);
    apb(1'b0, 12'h102, 32'h0, rd, err);
    chk("misaligned error", err, 32'h1);
    chk("misaligned data", rd, 32'h0);
    rd_chk(LRT_FLAGS, 32'h00FF01FF, "flags");
  endtask : check_regs

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    req = '0;
    per = 8'd8;
    hi = 8'd0;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wr(LRT_PRESCALE, 32'h0);
    wr(LRT_CTRL, 32'h1);
    check_pwm();
    check_edges();
    check_capture();
    check_regs();
    give_verdict();
  end
endmodule : lrt_timer_bench
